// ===== logic/etp_timer.sv
// Purpose: event driven state timer and pwm core
// Assumes: config ports are static while counters run; pins are asynchronous
// Notes:   actions come from the sixteen events or match 0 auto limit; software writes matches, clears and unhalts
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - one 32-bit or two 16-bit counters
// - count on clock or selected input edge
// - up to sixteen match or capture registers
// - match 0..5 carry fractional dither part
// - capture copies count into capture register
// - ten single or eight dual edge outputs
// - events from match, io edge/level, combination
// - events start, stop, halt, limit, reverse counter
// - events change state, toggle outputs, irq, dma
// - match 0 optionally acts as automatic limit
// - events qualified by count direction when bidirectional
// - match may stay pending until io condition
// - event fires only in its enabled states
// - events load state; state survives counter wraps
// - limit clears unidirectional, reverses bidirectional
module etp_timer (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // configuration
  input wire etp_pkg::etp_cfg_t cfg_i,
  input wire etp_pkg::etp_ev_cfg_t [etp_pkg::NUM_EV-1:0] ev_cfg_i,
  input wire etp_pkg::etp_mr_wr_t mr_wr_i,
  // software control pulses
  input wire logic [1:0] sw_unhalt_i,
  input wire logic sw_clr_i,
  // pins
  input wire logic [etp_pkg::NUM_IN-1:0] pin_i,
  output logic [etp_pkg::NUM_OUT-1:0] out_o,
  // requests and status
  output logic irq_o,
  output logic dma_o,
  output logic [etp_pkg::NUM_EV-1:0] ev_fired_o,
  output logic [etp_pkg::ST_W-1:0] state_o,
  output logic [etp_pkg::CNT_W-1:0] cnt_lo_o,
  output logic [etp_pkg::HALF_W-1:0] cnt_hi_o,
  output logic [1:0] down_o,
  output logic [1:0] halted_o,
  output logic [1:0] stopped_o,
  output logic [etp_pkg::NUM_MR-1:0][etp_pkg::CNT_W-1:0] mr_o
);
  import etp_pkg::*;

  // ==========================================================================
  // input synchronisers
  logic [NUM_IN-1:0] in_lvl;
  logic [NUM_IN-1:0] in_rise;
  logic [NUM_IN-1:0] in_fall;

  for (genvar i = 0; i < NUM_IN; i++) begin : g_sync
    etp_sync u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .d_i(pin_i[i]),
      .lvl_o(in_lvl[i]),
      .rise_o(in_rise[i]),
      .fall_o(in_fall[i])
    );
  end

  // ==========================================================================
  // core state and working signals
  etp_st_t st_r;
  etp_st_t st_nxt;
  logic tick;
  logic [1:0] adv;
  logic [1:0][NUM_MR-1:0] mv;
  logic [1:0] lim;
  logic [1:0] lim_all;
  logic [1:0] rev;
  logic [1:0] start_ev;
  logic [1:0] stop_ev;
  logic [1:0] halt_ev;
  logic [NUM_EV-1:0] fire;
  logic [NUM_EV-1:0] st_ok;
  logic [NUM_OUT-1:0] tog_v;
  logic [FRAC_W-1:0] phase_rev;
  logic [CNT_W-1:0] mval;
  logic [CNT_W-1:0] cur;
  logic [CNT_W-1:0] cap_val;
  logic [3:0] cap_idx;
  logic cap_any;
  logic ld_any;
  logic u;
  logic mhit;
  logic mt;
  logic io_lv;
  logic io_ri;
  logic io_fa;
  logic ioh;
  logic cond;
  logic dok;
  logic d;
  logic [4:0] osel;

  always_comb begin
    st_nxt = st_r;
    // input clocking gives one count per selected edge
    tick = cfg_i.clk_in ? in_rise[cfg_i.clk_sel] : 1'b1;
    adv[0] = tick & ~st_r.halt[0] & ~st_r.stop[0];
    adv[1] = tick & ~st_r.halt[1] & ~st_r.stop[1] & ~cfg_i.unify;
    phase_rev = {<<{st_r.dphase}};
    // match compare per unit; the dither adds one count on a spread subset of periods
    for (int m = 0; m < NUM_MR; m++) begin
      mval = st_r.mr[m] + {31'h0, st_r.frac[m] > phase_rev};
      if (cfg_i.unify) begin
        mv[0][m] = (st_r.cnt0 == mval);
      end else begin
        mv[0][m] = (st_r.cnt0[15:0] == mval[15:0]);
      end
      mv[1][m] = (st_r.cnt1 == st_r.mr[m][31:16]);
      // a register set aside for capture never matches
      mv[0][m] = mv[0][m] & adv[0] & ~cfg_i.is_cap[m];
      mv[1][m] = mv[1][m] & adv[1] & ~cfg_i.is_cap[m];
    end
    // software write first so that a capture in the same cycle wins
    if (mr_wr_i.wr) begin
      st_nxt.mr[mr_wr_i.idx] = mr_wr_i.data;
      if (mr_wr_i.idx < 4'(NUM_FRAC)) begin
        st_nxt.frac[mr_wr_i.idx] = mr_wr_i.frac;
      end
    end
    lim = '0;
    rev = '0;
    start_ev = '0;
    stop_ev = '0;
    halt_ev = '0;
    tog_v = '0;
    cap_any = 1'b0;
    cap_idx = '0;
    cap_val = '0;
    ld_any = 1'b0;
    st_nxt.irq = 1'b0;
    st_nxt.dma = 1'b0;
    // ========================================================================
    // event evaluation
    for (int e = 0; e < NUM_EV; e++) begin
      u = ev_cfg_i[e].unit_hi & ~cfg_i.unify;
      mhit = mv[u][ev_cfg_i[e].mr_sel];
      osel = ev_cfg_i[e].io_sel - 5'(IO_OUT_BASE);
      io_lv = 1'b0;
      io_ri = 1'b0;
      io_fa = 1'b0;
      // outputs can be watched as well as inputs
      if (ev_cfg_i[e].io_sel < 5'(IO_OUT_BASE)) begin
        io_lv = in_lvl[ev_cfg_i[e].io_sel[2:0]];
        io_ri = in_rise[ev_cfg_i[e].io_sel[2:0]];
        io_fa = in_fall[ev_cfg_i[e].io_sel[2:0]];
      end else if (ev_cfg_i[e].io_sel < 5'(IO_OUT_END)) begin
        io_lv = st_r.outp[osel[3:0]];
        io_ri = st_r.outp[osel[3:0]] & ~st_r.out_prev[osel[3:0]];
        io_fa = ~st_r.outp[osel[3:0]] & st_r.out_prev[osel[3:0]];
      end
      case (ev_cfg_i[e].io_cond)
        IO_LOW: ioh = ~io_lv;
        IO_RISE: ioh = io_ri;
        IO_FALL: ioh = io_fa;
        default: ioh = io_lv;
      endcase
      mt = mhit | (ev_cfg_i[e].hold & st_r.pend[e]);
      case (ev_cfg_i[e].comb)
        CMB_OR: cond = mt | ioh;
        CMB_MATCH: cond = mt;
        CMB_IO: cond = ioh;
        default: cond = mt & ioh;
      endcase
      // direction qualifier only bites in bidirectional mode
      case (ev_cfg_i[e].dirq)
        DQ_UP: dok = ~cfg_i.bidir[u] | ~st_r.down[u];
        DQ_DOWN: dok = ~cfg_i.bidir[u] | st_r.down[u];
        DQ_ANY: dok = 1'b1;
        default: dok = ~cfg_i.bidir[u];
      endcase
      st_ok[e] = ev_cfg_i[e].st_mask[st_r.state];
      fire[e] = cond & dok & st_ok[e];
      // a held match waits for the io side, and is consumed when the event fires
      st_nxt.pend[e] = ~fire[e] & (st_r.pend[e] | (ev_cfg_i[e].hold & mhit & st_ok[e]));
      if (fire[e]) begin
        lim[u] = lim[u] | ev_cfg_i[e].limit;
        rev[u] = rev[u] ^ ev_cfg_i[e].rev;
        start_ev[u] = start_ev[u] | ev_cfg_i[e].start;
        stop_ev[u] = stop_ev[u] | ev_cfg_i[e].stop;
        halt_ev[u] = halt_ev[u] | ev_cfg_i[e].halt;
        tog_v = tog_v ^ ev_cfg_i[e].tog;
        st_nxt.irq = st_nxt.irq | ev_cfg_i[e].irq;
        st_nxt.dma = st_nxt.dma | ev_cfg_i[e].dma;
        if (ev_cfg_i[e].ld_state) begin
          ld_any = 1'b1;
          st_nxt.state = ev_cfg_i[e].nxt_state;
        end
        // capture the count as it stood when the event fired
        if (ev_cfg_i[e].cap_en && cfg_i.is_cap[ev_cfg_i[e].cap_sel]) begin
          cap_any = 1'b1;
          cap_idx = ev_cfg_i[e].cap_sel;
          cap_val = u ? {16'h0000, st_r.cnt1} : st_r.cnt0;
          st_nxt.mr[ev_cfg_i[e].cap_sel] = cap_val;
        end
      end
    end
    st_nxt.fired = fire;
    st_nxt.out_prev = st_r.outp;
    st_nxt.outp = st_r.outp ^ tog_v;
    // dither phase steps once per unit 0 period
    if (adv[0] && st_r.cnt0 == '0) begin
      st_nxt.dphase = st_r.dphase + 5'h01;
    end
    // ========================================================================
    // counter update per unit
    for (int k = 0; k < 2; k++) begin
      cur = (k == 0) ? st_r.cnt0 : {16'h0000, st_r.cnt1};
      lim_all[k] = lim[k] | (cfg_i.auto_lim[k] & mv[k][AUTO_LIM_MR]);
      d = (st_r.down[k] ^ rev[k]) & cfg_i.bidir[k];
      if (adv[k]) begin
        if (lim_all[k] && !cfg_i.bidir[k]) begin
          cur = '0;
        end else begin
          if (lim_all[k]) begin
            d = ~d;
          end else if (cfg_i.bidir[k] && d && cur == '0) begin
            d = 1'b0;
          end
          cur = d ? cur - 32'h1 : cur + 32'h1;
        end
      end
      if (sw_clr_i) begin
        cur = '0;
        d = 1'b0;
      end
      st_nxt.down[k] = d;
      // halt needs software to release it, stop is undone by a start event
      st_nxt.halt[k] = (st_r.halt[k] & ~sw_unhalt_i[k]) | halt_ev[k];
      st_nxt.stop[k] = (st_r.stop[k] & ~start_ev[k]) | stop_ev[k];
      if (k == 0) begin
        st_nxt.cnt0 = cfg_i.unify ? cur : {16'h0000, cur[15:0]};
      end else begin
        st_nxt.cnt1 = cur[15:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign out_o = st_r.outp;
  assign irq_o = st_r.irq;
  assign dma_o = st_r.dma;
  assign ev_fired_o = st_r.fired;
  assign state_o = st_r.state;
  assign cnt_lo_o = st_r.cnt0;
  assign cnt_hi_o = st_r.cnt1;
  assign down_o = st_r.down;
  assign halted_o = st_r.halt;
  assign stopped_o = st_r.stop;
  assign mr_o = st_r.mr;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_halt_then_hold;
    halt_ev[0] ##1 (st_r.halt[0] && !sw_unhalt_i[0]);
  endsequence

  halt_holds_a: assert property (s_halt_then_hold |=> st_r.halt[0])
    else $error("halt released without software");
  halt_freeze_a: assert property ((st_r.halt[0] && !sw_clr_i) |=> $stable(st_r.cnt0))
    else $error("halted counter moved");
  uni_limit_a: assert property ((adv[0] && lim_all[0] && !cfg_i.bidir[0] && !sw_clr_i) |=> st_r.cnt0 == '0)
    else $error("limit did not clear counter");
  bidir_limit_a: assert property ((adv[0] && lim_all[0] && cfg_i.bidir[0] && !rev[0] && !sw_clr_i)
      |=> st_r.down[0] != $past(st_r.down[0]))
    else $error("limit did not reverse direction");
  auto_limit_a: assert property ((cfg_i.auto_lim[0] && mv[0][0] && !cfg_i.bidir[0] && !sw_clr_i)
      |=> st_r.cnt0 == '0)
    else $error("auto limit on match 0 failed");
  // a software clear may still zero a stale high half after a mode change
  split_hi_a: assert property ((cfg_i.unify && !sw_clr_i) |=> $stable(st_r.cnt1))
    else $error("high half moved in unified mode");
  state_gate_a: assert property ((ev_fired_o != '0) |-> ((ev_fired_o & ~$past(st_ok)) == '0))
    else $error("event fired outside enabled state");
  state_keep_a: assert property (!ld_any |=> $stable(st_r.state))
    else $error("state changed without load event");
  capture_a: assert property (cap_any |=> st_r.mr[$past(cap_idx)] == $past(cap_val))
    else $error("capture value not stored");
  toggle_a: assert property (1'b1 |=> out_o == $past(st_r.outp ^ tog_v))
    else $error("output toggle mismatch");
  dir_qual_a: assert property ((fire[1] && ev_cfg_i[1].dirq == DQ_UP
      && cfg_i.bidir[0] && !ev_cfg_i[1].unit_hi) |-> !st_r.down[0])
    else $error("up qualified event fired counting down");
  dir_down_a: assert property ((fire[0] && ev_cfg_i[0].dirq == DQ_DOWN
      && cfg_i.bidir[0] && !ev_cfg_i[0].unit_hi) |-> st_r.down[0])
    else $error("down qualified event fired counting up");

endmodule : etp_timer
`default_nettype wire

// ===== logic/etp_pkg.sv
// Purpose: shared types and constants of the event driven state timer / pwm
// Assumes: single 20 MHz clock, configuration held steady by software while running
// Notes:   event and counter configuration travel as packed structs
package etp_pkg;

  // ==========================================================================
  // sizes and fixed counts
  localparam int NUM_IN = 8;
  localparam int NUM_OUT = 10;
  localparam int NUM_EV = 16;
  localparam int NUM_MR = 16;
  localparam int NUM_FRAC = 6;
  localparam int ST_W = 5;
  localparam int FRAC_W = 5;
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;
  localparam int IO_OUT_BASE = 8;
  localparam int IO_OUT_END = 18;
  localparam logic [3:0] AUTO_LIM_MR = 4'h0;

  // ==========================================================================
  // reset values
  localparam logic [1:0] HALT_RST = 2'h3;
  localparam logic [ST_W-1:0] STATE_RST = 5'h00;

  // ==========================================================================
  // field encodings
  typedef enum logic [1:0] {IO_LOW, IO_RISE, IO_FALL, IO_HIGH} etp_iocond_t;
  typedef enum logic [1:0] {CMB_OR, CMB_MATCH, CMB_IO, CMB_AND} etp_comb_t;
  typedef enum logic [1:0] {DQ_ANY, DQ_UP, DQ_DOWN, DQ_NONE} etp_dirq_t;

  // ==========================================================================
  // per event configuration
  typedef struct packed {
    logic [31:0] st_mask;   // states in which the event may fire
    logic [3:0] mr_sel;
    logic [4:0] io_sel;     // 0..7 inputs, 8..17 outputs
    etp_iocond_t io_cond;
    etp_comb_t comb;
    etp_dirq_t dirq;
    logic hold;             // keep match pending until io condition
    logic unit_hi;          // high half counter when split
    logic start;
    logic stop;
    logic halt;
    logic limit;
    logic rev;
    logic cap_en;
    logic [3:0] cap_sel;
    logic ld_state;
    logic [ST_W-1:0] nxt_state;
    logic [NUM_OUT-1:0] tog;
    logic irq;
    logic dma;
  } etp_ev_cfg_t;

  // counter configuration
  typedef struct packed {
    logic unify;            // one 32-bit counter
    logic [1:0] bidir;
    logic [1:0] auto_lim;
    logic clk_in;           // count on selected input rising edges
    logic [2:0] clk_sel;
    logic [NUM_MR-1:0] is_cap;
  } etp_cfg_t;

  // software write of one match register
  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    logic [CNT_W-1:0] data;
    logic [FRAC_W-1:0] frac;
  } etp_mr_wr_t;

  // input synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } etp_sync_st_t;

  // whole state of the timer core
  typedef struct packed {
    logic [CNT_W-1:0] cnt0;
    logic [HALF_W-1:0] cnt1;
    logic [1:0] down;
    logic [1:0] halt;
    logic [1:0] stop;
    logic [ST_W-1:0] state;
    logic [NUM_EV-1:0] pend;
    logic [NUM_OUT-1:0] outp;
    logic [NUM_OUT-1:0] out_prev;
    logic [NUM_EV-1:0] fired;
    logic irq;
    logic dma;
    logic [FRAC_W-1:0] dphase;
    logic [NUM_MR-1:0][CNT_W-1:0] mr;
    logic [NUM_MR-1:0][FRAC_W-1:0] frac;
  } etp_st_t;

  localparam etp_st_t ST_RST = '{halt: HALT_RST, state: STATE_RST, default: '0};

endpackage : etp_pkg

// ===== logic/etp_sync.sv
// Purpose: two flop synchroniser with edge detect for one timer input pin
// Assumes: pin is asynchronous to mclk_i
// Notes:   first flop feeds only the second flop
`timescale 1ns/1ps
`default_nettype none
module etp_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // pin and results
  input wire logic d_i,
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);
  import etp_pkg::*;

  etp_sync_st_t st_r;
  etp_sync_st_t st_nxt;

  // shift chain, s3 only remembers the last synchronised level
  always_comb begin
    st_nxt = '{s1: d_i, s2: st_r.s1, s3: st_r.s2};
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lvl_o = st_r.s2;
  assign rise_o = st_r.s2 & ~st_r.s3;
  assign fall_o = ~st_r.s2 & st_r.s3;

endmodule : etp_sync
`default_nettype wire

// ===== tb/etp_pin_model.sv
// Purpose: pin side model that drives the eight timer input pins
// Assumes: the bench asks for pin levels between clock edges
// Notes:   pins move just after a rising edge, never in the bench's drive step
`timescale 1ns/1ps
`default_nettype none
module etp_pin_model (
  // clock
  input wire logic mclk_i,
  // requested levels
  input wire logic [etp_pkg::NUM_IN-1:0] lvl_i,
  // pins towards the timer
  output logic [etp_pkg::NUM_IN-1:0] pin_o
);
  import etp_pkg::*;
  // ==========================================================================
  // pin drivers
  // driven lines always show a level, so start all low rather than unknown;
  // launch on the rising edge so the bench's falling edge writes never race us
  initial begin
    pin_o = '0;
    forever @(posedge mclk_i) pin_o <= lvl_i;
  end
endmodule : etp_pin_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self checking bench of the event driven timer core
// Assumes: inputs move on the falling edge, outputs read there too
// Notes:   one task per scenario; expectations come from match values set here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import etp_pkg::*;
  // ==========================================================================
  // signals
  logic mclk;
  logic rst;
  etp_cfg_t cfg;
  etp_ev_cfg_t [NUM_EV-1:0] ev;
  etp_mr_wr_t mrw;
  logic [1:0] unh;
  logic clr;
  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] pin;
  logic [NUM_OUT-1:0] out;
  logic irq;
  logic dma;
  logic [NUM_EV-1:0] fired;
  logic [ST_W-1:0] st;
  logic [CNT_W-1:0] cnt_lo;
  logic [HALF_W-1:0] cnt_hi;
  logic [1:0] down;
  logic [1:0] halted;
  logic [1:0] stopped;
  logic [NUM_MR-1:0][CNT_W-1:0] mr;
  int n_mismatch;
  int n_tests;

  // ==========================================================================
  // instances
  etp_timer i_etp_timer (.mclk_i(mclk), .rst_i(rst), .cfg_i(cfg), .ev_cfg_i(ev), .mr_wr_i(mrw),
    .sw_unhalt_i(unh), .sw_clr_i(clr), .pin_i(pin), .out_o(out), .irq_o(irq), .dma_o(dma),
    .ev_fired_o(fired), .state_o(st), .cnt_lo_o(cnt_lo), .cnt_hi_o(cnt_hi), .down_o(down),
    .halted_o(halted), .stopped_o(stopped), .mr_o(mr));
  etp_pin_model i_etp_pin_model (.mclk_i(mclk), .lvl_i(lvl), .pin_o(pin));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(negedge mclk);
  endtask : tk

  // bounded wait: a missing event must not hang the run
  task automatic wait_ev(input int k, input int lim);
    for (int i = 0; i < lim; i++) begin
      tk(1);
      if (fired[k] === 1'b1) break;
    end
    chk("event fired", 1, fired[k]);
  endtask : wait_ev

  // clears every configuration input so scenarios cannot leak into each other
  // reset goes up first so that no input is written twice in the step that ended the last scenario
  task automatic do_reset(input int n);
    rst = 1'b1;
    tk(1);
    cfg = '0;
    ev = '0;
    mrw = '0;
    unh = 2'h0;
    clr = 1'b0;
    lvl = '0;
    tk(n - 1);
    rst = 1'b0;
  endtask : do_reset

  task automatic wr_mr(input logic [3:0] idx, input logic [31:0] data);
    mrw.wr = 1'b1;
    mrw.idx = idx;
    mrw.data = data;
    mrw.frac = 5'h00;
    tk(1);
    mrw.wr = 1'b0;
    // one idle edge so a following write never re-raises the strobe in this step
    tk(1);
  endtask : wr_mr

  task automatic unhalt(input logic [1:0] m);
    unh = m;
    tk(1);
    unh = 2'h0;
  endtask : unhalt

  // matching event setup shared by several scenarios
  task automatic set_match(input int k, input logic [3:0] sel);
    ev[k].st_mask = '1;
    ev[k].mr_sel = sel;
    ev[k].comb = CMB_MATCH;
  endtask : set_match

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    do_reset(10);
    chk("halted after reset", 3, halted);
    chk("state after reset", 0, st);
    chk("outputs after reset", 0, out);
    chk("count after reset", 0, cnt_lo);
  endtask : t_reset

  task automatic t_limit_state;
    int seen;
    do_reset(2);
    cfg.unify = 1'b1;
    cfg.is_cap = 16'h0004;
    wr_mr(4'h0, 32'h0000_0009);
    wr_mr(4'h1, 32'h0000_0006);
    set_match(0, 4'h0);
    ev[0].limit = 1'b1;
    ev[0].tog = 10'h001;
    ev[0].irq = 1'b1;
    set_match(1, 4'h1);
    ev[1].st_mask = 32'h0000_0001;
    ev[1].ld_state = 1'b1;
    ev[1].nxt_state = 5'h03;
    ev[1].cap_en = 1'b1;
    ev[1].cap_sel = 4'h2;
    ev[1].dma = 1'b1;
    unhalt(2'h1);
    wait_ev(1, 20);
    chk("state loaded", 3, st);
    chk("captured count", 6, mr[2]);
    chk("dma request", 1, dma);
    wait_ev(0, 10);
    chk("count after limit", 0, cnt_lo);
    chk("output toggled", 1, out[0]);
    chk("irq request", 1, irq);
    seen = 0;
    repeat (24) begin
      tk(1);
      if (fired[1] === 1'b1) seen++;
    end
    chk("event outside its states", 0, seen);
    chk("state across wraps", 3, st);
  endtask : t_limit_state

  task automatic t_bidir;
    logic [31:0] mx;
    int nf;
    int nu;
    do_reset(2);
    cfg.bidir = 2'h1;
    cfg.auto_lim = 2'h1;
    wr_mr(4'h0, 32'h0000_0004);
    wr_mr(4'h1, 32'h0000_0002);
    set_match(0, 4'h1);
    ev[0].dirq = DQ_DOWN;
    ev[0].irq = 1'b1;
    set_match(1, 4'h1);
    ev[1].dirq = DQ_UP;
    unhalt(2'h3);
    mx = '0;
    nf = 0;
    nu = 0;
    repeat (30) begin
      tk(1);
      if (cnt_lo > mx) mx = cnt_lo;
      if (fired[0] === 1'b1) begin
        nf++;
        chk("direction at event", 1, down[0]);
      end
      if (fired[1] === 1'b1) begin
        nu++;
        chk("direction at up event", 0, down[0]);
      end
    end
    chk("up events seen", 1, nu > 0);
    chk("peak of auto limit", 4, mx);
    chk("down events seen", 1, nf > 0);
    chk("split upper half", 0, cnt_lo[31:16]);
    chk("second unit runs", 1, cnt_hi > 16'h0000);
    clr = 1'b1;
    tk(1);
    clr = 1'b0;
    chk("cleared count", 0, {cnt_hi, cnt_lo[15:0]});
  endtask : t_bidir

  task automatic t_pin;
    logic [31:0] c0;
    do_reset(2);
    cfg.unify = 1'b1;
    cfg.clk_in = 1'b1;
    cfg.clk_sel = 3'h1;
    ev[0].st_mask = '1;
    ev[0].io_sel = 5'h00;
    ev[0].io_cond = IO_RISE;
    ev[0].comb = CMB_IO;
    ev[0].tog = 10'h002;
    unhalt(2'h1);
    tk(2);
    c0 = cnt_lo;
    // five rising edges, each level held long enough to pass the synchroniser
    repeat (5) begin
      lvl[1] = 1'b1;
      tk(3);
      lvl[1] = 1'b0;
      tk(3);
    end
    tk(4);
    chk("pin clocked count", c0 + 5, cnt_lo);
    lvl[0] = 1'b1;
    wait_ev(0, 8);
    chk("output from pin edge", 1, out[1]);
  endtask : t_pin

  task automatic t_halt;
    logic [31:0] c0;
    do_reset(2);
    cfg.unify = 1'b1;
    wr_mr(4'h1, 32'h0000_0003);
    set_match(0, 4'h1);
    ev[0].halt = 1'b1;
    unhalt(2'h1);
    wait_ev(0, 10);
    chk("halted by event", 1, halted[0]);
    c0 = cnt_lo;
    tk(5);
    chk("count frozen", c0, cnt_lo);
  endtask : t_halt

  // stop and start by events, a held match, and an event on an output edge
  task automatic t_stop_hold;
    logic [31:0] c0;
    do_reset(2);
    cfg.unify = 1'b1;
    wr_mr(4'h1, 32'h0000_0003);
    wr_mr(4'h2, 32'h0000_0007);
    set_match(0, 4'h1);
    ev[0].stop = 1'b1;
    ev[1].st_mask = '1;
    ev[1].io_sel = 5'h02;
    ev[1].io_cond = IO_RISE;
    ev[1].comb = CMB_IO;
    ev[1].start = 1'b1;
    set_match(2, 4'h2);
    ev[2].hold = 1'b1;
    ev[2].comb = CMB_AND;
    ev[2].io_sel = 5'h03;
    ev[2].io_cond = IO_HIGH;
    ev[2].tog = 10'h004;
    ev[3].st_mask = '1;
    ev[3].io_sel = 5'h0A;
    ev[3].io_cond = IO_RISE;
    ev[3].comb = CMB_IO;
    ev[3].tog = 10'h008;
    unhalt(2'h1);
    wait_ev(0, 10);
    chk("stopped by event", 1, stopped[0]);
    c0 = cnt_lo;
    tk(3);
    chk("count while stopped", c0, cnt_lo);
    lvl[2] = 1'b1;
    wait_ev(1, 8);
    chk("started by event", 0, stopped[0]);
    tk(8);
    chk("held match waits", 0, out[2]);
    lvl[3] = 1'b1;
    wait_ev(2, 8);
    chk("held match fired", 1, out[2]);
    tk(1);
    chk("output edge event", 1, out[3]);
  endtask : t_stop_hold

  // ==========================================================================
  // run control
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    t_reset();
    t_limit_state();
    t_bidir();
    t_pin();
    t_halt();
    t_stop_hold();
    test_done();
  end

  // the scenarios need under two hundred cycles; fifteen times that means a hang
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
